/* testbench/sfp_host.sv */
// Host model that clocks command frames into the sequencer over the serial link.
`timescale 1ns/100ps
module sfp_host
    import sfp_pkg::*;
(
    // Clock
    input  wire logic clk,
    // Serial link pins
    output logic      sck,
    output logic      cs_n,
    output logic      si
);
    initial
    begin
        sck  = 1'b0;
        cs_n = 1'b1;
        si   = 1'b0;
    end

    // Outside a frame the data line toggles, so a stale bit never looks valid.
    always @(posedge clk)
    begin
        if (cs_n)
        begin
            si <= ~si;
        end
    end

    // Sends nbits of the byte queue MSB first in mode 0; the clock rests low between frames.
    task automatic frame(input logic [7:0] b [$], input int nbits);
        int i;
        @(posedge clk);
        cs_n <= 1'b0;
        for (i = 0; i < nbits; i++)
        begin
            repeat (4) @(posedge clk);
            si <= b[i / 8][7 - i % 8];
            repeat (4) @(posedge clk);
            sck <= 1'b1;
            repeat (8) @(posedge clk);
            sck <= 1'b0;
        end
        repeat (8) @(posedge clk);
        cs_n <= 1'b1;
        repeat (16) @(posedge clk);
    endtask : frame
endmodule : sfp_host

/* testbench/sfp_seq_tb.sv */
// Self-checking bench for the program and erase sequencer.
`timescale 1ns/100ps
module sfp_seq_tb
    import sfp_pkg::*;
;
    localparam int PP  = 300;
    localparam int BP  = 20;
    localparam int BLK = 2000;

    logic         clk = 1'b0;
    logic         rst_n;
    logic         prot_wr;
    logic [3:0]   prot_wdata;
    logic         arr_fail;
    logic         sck;
    logic         cs_n;
    logic         si;
    sfp_status_t  status_o;
    logic [3:0]   prot_o;
    sfp_arr_cmd_t arr_cmd_o;
    int           failures = 0;
    int           total_checks = 0;
    int           seed = 39;
    int           busy_n;
    int           n;
    logic [17:0]  wa [$];
    logic [7:0]   wd [$];
    logic [17:0]  ea [$];
    logic [1:0]   es [$];
    logic [7:0]   dq [$];
    logic [7:0]   ef [$];

    always #5 clk = ~clk;

    sfp_host host (.clk(clk), .sck(sck), .cs_n(cs_n), .si(si));

    sfp_seq #(.PP_CYC(PP), .BP_CYC(BP), .BLK_CYC(BLK)) dut (
        .clk(clk), .rst_n(rst_n), .sck(sck), .cs_n(cs_n), .si(si),
        .prot_wr(prot_wr), .prot_wdata(prot_wdata), .status_o(status_o),
        .prot_o(prot_o), .arr_cmd_o(arr_cmd_o), .arr_fail(arr_fail)
    );

    // Array requests are logged on the falling edge, where they are settled.
    always @(negedge clk)
    begin
        if (arr_cmd_o.wr === 1'b1)
        begin
            wa.push_back(arr_cmd_o.addr);
            wd.push_back(arr_cmd_o.wdata);
        end
        if (arr_cmd_o.erase === 1'b1)
        begin
            ea.push_back(arr_cmd_o.addr);
            es.push_back(arr_cmd_o.size);
            ef.push_back(arr_cmd_o.wdata);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic stop_test();
        if (failures == 0 && total_checks > 0)
        begin
            $display("ALL TESTS PASSED");
        end
        else
        begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : stop_test

    task automatic chk_flag(input string nm, input logic e, input logic g);
        total_checks++;
        if (g !== e)
        begin
            $display("CHECK FAILED %s expected %b seen %b", nm, e, g);
            failures++;
        end
    endtask : chk_flag

    task automatic chk_word(input string nm, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e)
        begin
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
            failures++;
        end
    endtask : chk_word

    // Random address outside the sector that stays protected.
    function automatic logic [23:0] raddr();
        raddr = $random(seed);
        raddr[17] = 1'b1;
    endfunction : raddr

    task automatic send(input logic [7:0] op, input logic [23:0] a, input int nd, input int cut);
        logic [7:0] b [$];
        dq.delete();
        wa.delete();
        wd.delete();
        ea.delete();
        es.delete();
        ef.delete();
        b = {op, a[23:16], a[15:8], a[7:0]};
        repeat (nd) dq.push_back(8'($random(seed)));
        b = {b, dq};
        host.frame(b, 8 * b.size() - cut);
        #1;
    endtask : send

    task automatic we();
        send(OP_WRITE_EN, 24'h0, 0, 24);
    endtask : we

    task automatic wait_idle();
        busy_n = 0;
        #1;
        while (status_o.busy === 1'b1)
        begin
            @(posedge clk);
            #1;
            busy_n++;
            if (busy_n > 5000)
            begin
                failures++;
                stop_test();
            end
        end
    endtask : wait_idle

    task automatic prog(input logic [23:0] a, input int nd);
        logic [7:0] m [int];
        we();
        send(OP_PROGRAM, a, nd, 0);
        chk_flag("busy", 1'b1, status_o.busy);
        chk_flag("write enable", 1'b0, status_o.write_enable_latch_flag);
        wait_idle();
        chk_flag("program time", 1'b1, busy_n <= ((nd == 1) ? BP : PP) + 2);
        chk_flag("error flag", 1'b0, status_o.program_erase_error_flag);
        for (int k = 0; k < nd; k++)
        begin
            m[{a[17:8], 8'(a[7:0] + k)}] = dq[k];
        end
        chk_word("program count", m.num(), wa.size());
        foreach (wa[i])
        begin
            chk_word("program data", m.exists(wa[i]) ? m[wa[i]] : 9'h100, wd[i]);
        end
    endtask : prog

    task automatic refused(input logic [7:0] op, input logic [23:0] a, input int nd, input int cut);
        we();
        send(op, a, nd, cut);
        chk_word("array ops", 0, wa.size() + ea.size());
        chk_flag("write enable", 1'b0, status_o.write_enable_latch_flag);
    endtask : refused

    task automatic erase(input logic [7:0] op, input logic [1:0] sz, input logic [17:0] msk);
        logic [23:0] a;
        a = raddr();
        we();
        send(op, a, 1, 0);
        chk_flag("busy", 1'b1, status_o.busy);
        chk_flag("write enable", 1'b0, status_o.write_enable_latch_flag);
        wait_idle();
        chk_flag("erase time", 1'b1, busy_n >= BLK - 20);
        chk_word("erase count", 1, ea.size());
        chk_word("erase base", a[17:0] & ~msk, ea[0]);
        chk_word("erase size", sz, es[0]);
        chk_word("erase fill", ERASED_BYTE, ef[0]);
    endtask : erase

    task automatic faulty(input logic [7:0] op);
        we();
        send(op, raddr(), 2, 0);
        chk_flag("error clear", 1'b0, status_o.program_erase_error_flag);
        @(posedge clk);
        arr_fail <= 1'b1;
        @(posedge clk);
        arr_fail <= 1'b0;
        wait_idle();
        chk_flag("error flag", 1'b1, status_o.program_erase_error_flag);
    endtask : faulty

    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        rst_n = 1'b0;
        prot_wr = 1'b0;
        prot_wdata = 4'h0;
        arr_fail = 1'b0;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        repeat (10) @(posedge clk);
        #1;
        chk_word("protection", 4'hF, prot_o);
        refused(OP_PROGRAM, 24'h000010, 1, 0);
        @(posedge clk);
        prot_wr <= 1'b1;
        prot_wdata <= 4'h2;
        @(posedge clk);
        prot_wr <= 1'b0;
        send(OP_PROGRAM, 24'h000010, 1, 0);
        send(OP_ERASE_4K, 24'h000010, 0, 0);
        chk_word("no enable ops", 0, wa.size() + ea.size());
        we();
        chk_flag("write enable", 1'b1, status_o.write_enable_latch_flag);
        prog(24'h0000FE, 3);
        prog(24'hFC0000 | raddr(), 1);
        repeat (3)
        begin
            n = 1 + {$random(seed)} % 40;
            prog(raddr(), n);
        end
        prog(raddr(), 258);
        refused(OP_PROGRAM, raddr(), 1, 3);
        refused(OP_PROGRAM, raddr(), 0, 0);
        refused(OP_PROGRAM, raddr(), 0, 8);
        refused(OP_ERASE_4K, raddr(), 0, 8);
        refused(OP_ERASE_32K, raddr(), 1, 3);
        refused(OP_ERASE_64K, 24'h01F000, 0, 0);
        erase(OP_ERASE_4K, SZ_4K, 18'h00FFF);
        erase(OP_ERASE_32K, SZ_32K, 18'h07FFF);
        erase(OP_ERASE_64K, SZ_64K, 18'h0FFFF);
        faulty(OP_PROGRAM);
        faulty(OP_ERASE_4K);
        we();
        send(OP_ERASE_4K, raddr(), 0, 0);
        we();
        wait_idle();
        chk_flag("busy refusal", 1'b0, status_o.write_enable_latch_flag);
        stop_test();
    end
endmodule : sfp_seq_tb

/* verilog/sfp_pkg.sv */
// Constants and types for the serial flash program and erase sequencer.
package sfp_pkg;

    localparam int          CLK_MHZ        = 100;
    localparam int          ADDR_W         = 18;
    localparam int          SECTORS        = 4;
    localparam int          DATA_IDX       = 4;
    localparam logic [8:0]  PAGE_BYTES     = 9'h100;

    localparam logic [7:0]  OP_PROGRAM     = 8'h02;
    localparam logic [7:0]  OP_ERASE_4K    = 8'h20;
    localparam logic [7:0]  OP_ERASE_32K   = 8'h52;
    localparam logic [7:0]  OP_ERASE_64K   = 8'hD8;
    localparam logic [7:0]  OP_WRITE_EN    = 8'h06;
    localparam logic [7:0]  ERASED_BYTE    = 8'hFF;

    localparam logic [SECTORS-1:0] PROT_RESET = 4'hF;

    // Self-timed durations; plain defaults, shortened through top parameters in simulation.
    localparam int PAGE_PROGRAM_TIME_US = 1000;
    localparam int BYTE_PROGRAM_TIME_US = 100;
    localparam int BLOCK_ERASE_TIME_MS  = 100;
    localparam int PAGE_PROGRAM_CYC = PAGE_PROGRAM_TIME_US * CLK_MHZ;
    localparam int BYTE_PROGRAM_CYC = BYTE_PROGRAM_TIME_US * CLK_MHZ;
    localparam int BLOCK_ERASE_CYC  = BLOCK_ERASE_TIME_MS * 1000 * CLK_MHZ;

    typedef enum logic [1:0] {
        SZ_4K  = 2'b00,
        SZ_32K = 2'b01,
        SZ_64K = 2'b10
    } sfp_esize_t;

    typedef struct packed {
        logic              wr;
        logic              erase;
        sfp_esize_t        size;
        logic [ADDR_W-1:0] addr;
        logic [7:0]        wdata;
    } sfp_arr_cmd_t;

    typedef struct packed {
        logic busy;
        logic write_enable_latch_flag;
        logic program_erase_error_flag;
    } sfp_status_t;

    function automatic sfp_esize_t sfp_erase_size(input logic [7:0] op);
        sfp_erase_size = (op == OP_ERASE_4K)  ? SZ_4K :
                         (op == OP_ERASE_32K) ? SZ_32K : SZ_64K;
    endfunction : sfp_erase_size

    function automatic logic [ADDR_W-1:0] sfp_block_mask(input sfp_esize_t s);
        sfp_block_mask = (s == SZ_4K)  ? 18'h00FFF :
                         (s == SZ_32K) ? 18'h07FFF : 18'h0FFFF;
    endfunction : sfp_block_mask

endpackage : sfp_pkg

/* verilog/sfp_seq.sv */
// Program and block erase command sequencer of a serial flash, device side.
`timescale 1ns/100ps
module sfp_seq
    import sfp_pkg::*;
#(
    parameter int PP_CYC  = PAGE_PROGRAM_CYC,
    parameter int BP_CYC  = BYTE_PROGRAM_CYC,
    parameter int BLK_CYC = BLOCK_ERASE_CYC
)(
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         rst_n,
    // Serial link pins
    input  wire logic         sck,
    input  wire logic         cs_n,
    input  wire logic         si,
    // Sector protection update
    input  wire logic         prot_wr,
    input  wire logic [3:0]   prot_wdata,
    // Status
    output sfp_status_t       status_o,
    output logic [3:0]        prot_o,
    // Array access
    output sfp_arr_cmd_t      arr_cmd_o,
    input  wire logic         arr_fail
);

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_PROG = 2'b01,
        ST_WAIT = 2'b10
    } sfp_state_t;

    ////////////////////////////////////////////////////////////////////////////////
    // Reset release and pin synchronisation.

    logic       rst_s1_q;
    logic       rst_sync_n;
    logic [2:0] pin_s;
    logic       sck_s;
    logic       cs_n_s;
    logic       si_s;
    logic       sck_q;
    logic       cs_n_q;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rst_s1_q   <= 1'b0;
            rst_sync_n <= 1'b0;
        end
        else
        begin
            rst_s1_q   <= 1'b1;
            rst_sync_n <= rst_s1_q;
        end
    end

    sfp_sync #(.W(3), .RST_VAL(3'h2)) u_sync (
        .clk   (clk),
        .rst_n (rst_sync_n),
        .d     ({sck, cs_n, si}),
        .q     (pin_s)
    );

    assign sck_s  = pin_s[2];
    assign cs_n_s = pin_s[1];
    assign si_s   = pin_s[0];

    always_ff @(posedge clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            sck_q  <= 1'b0;
            cs_n_q <= 1'b1;
        end
        else
        begin
            sck_q  <= sck_s;
            cs_n_q <= cs_n_s;
        end
    end

    logic sck_rise;
    logic cs_fall;
    logic cs_rise;

    assign sck_rise = sck_s && !sck_q && !cs_n_s;
    assign cs_fall  = !cs_n_s && cs_n_q;
    assign cs_rise  = cs_n_s && !cs_n_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Frame capture: opcode, address, data into the page buffer.

    sfp_state_t        st_q;
    sfp_state_t        st_d;
    logic [2:0]        bit_cnt_q;
    logic [2:0]        bit_cnt_d;
    logic [7:0]        shift_q;
    logic [7:0]        shift_d;
    logic [2:0]        byte_idx_q;
    logic [2:0]        byte_idx_d;
    logic [7:0]        op_q;
    logic [7:0]        op_d;
    logic [ADDR_W-1:0] addr_q;
    logic [ADDR_W-1:0] addr_d;
    logic [7:0]        wp_q;
    logic [7:0]        wp_d;
    logic [8:0]        data_cnt_q;
    logic [8:0]        data_cnt_d;
    logic              frame_ok_q;
    logic              frame_ok_d;
    logic [7:0]        byte_in;
    logic              buf_we;
    logic [7:0]        page_buf [256];

    assign byte_in = {shift_q[6:0], si_s};

    always_comb
    begin
        bit_cnt_d  = bit_cnt_q;
        shift_d    = shift_q;
        byte_idx_d = byte_idx_q;
        op_d       = op_q;
        addr_d     = addr_q;
        wp_d       = wp_q;
        data_cnt_d = data_cnt_q;
        frame_ok_d = frame_ok_q;
        buf_we     = 1'b0;
        if (cs_fall)
        begin
            bit_cnt_d  = 3'h0;
            byte_idx_d = 3'h0;
            data_cnt_d = 9'h000;
            frame_ok_d = (st_q == ST_IDLE);
        end
        else if (sck_rise && frame_ok_q)
        begin
            bit_cnt_d = bit_cnt_q + 3'h1;
            shift_d   = byte_in;
            if (bit_cnt_q == 3'h7)
            begin
                if (byte_idx_q != 3'(DATA_IDX))
                    byte_idx_d = byte_idx_q + 3'h1;
                unique case (byte_idx_q)
                    3'h0: op_d = byte_in;
                    3'h1: addr_d[17:16] = byte_in[1:0];
                    3'h2: addr_d[15:8] = byte_in;
                    3'h3:
                    begin
                        addr_d[7:0] = byte_in;
                        wp_d        = byte_in;
                    end
                    default:
                    begin
                        if (op_q == OP_PROGRAM)
                        begin
                            buf_we = 1'b1;
                            wp_d   = wp_q + 8'h01;
                            if (data_cnt_q != PAGE_BYTES)
                                data_cnt_d = data_cnt_q + 9'h001;
                        end
                    end
                endcase
            end
        end
    end

    always_ff @(posedge clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            bit_cnt_q  <= 3'h0;
            shift_q    <= 8'h00;
            byte_idx_q <= 3'h0;
            op_q       <= 8'h00;
            addr_q     <= '0;
            wp_q       <= 8'h00;
            data_cnt_q <= 9'h000;
            frame_ok_q <= 1'b0;
        end
        else
        begin
            bit_cnt_q  <= bit_cnt_d;
            shift_q    <= shift_d;
            byte_idx_q <= byte_idx_d;
            op_q       <= op_d;
            addr_q     <= addr_d;
            wp_q       <= wp_d;
            data_cnt_q <= data_cnt_d;
            frame_ok_q <= frame_ok_d;
        end
    end

    // Writes land at the wrapping pointer, so later bytes overwrite earlier ones.
    always_ff @(posedge clk)
    begin
        if (buf_we)
            page_buf[wp_q] <= byte_in;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Decision at chip-select release.

    logic end_frame;
    logic aligned;
    logic prot_hit;
    logic is_prog;
    logic is_erase;
    logic wren_ok;
    logic start_prog;
    logic start_erase;
    logic abort;
    logic [3:0] prot_q;
    logic       wel_q;

    assign end_frame = cs_rise && frame_ok_q && (st_q == ST_IDLE);
    assign aligned   = (bit_cnt_q == 3'h0);
    assign prot_hit  = prot_q[addr_q[17:16]];
    assign is_prog   = (byte_idx_q != 3'h0) && (op_q == OP_PROGRAM);
    assign is_erase  = (byte_idx_q != 3'h0) && ((op_q == OP_ERASE_4K)
                     || (op_q == OP_ERASE_32K) || (op_q == OP_ERASE_64K));
    assign wren_ok   = end_frame && aligned && (byte_idx_q != 3'h0)
                     && (op_q == OP_WRITE_EN);
    assign start_prog  = end_frame && is_prog && wel_q && aligned
                       && (data_cnt_q != 9'h000) && !prot_hit;
    assign start_erase = end_frame && is_erase && wel_q && aligned
                       && (byte_idx_q == 3'(DATA_IDX)) && !prot_hit;
    assign abort = end_frame && (is_prog || is_erase) && wel_q
                 && !start_prog && !start_erase;

    ////////////////////////////////////////////////////////////////////////////////
    // Self-timed execution and status.

    logic [ADDR_W-1:0] tgt_q;
    logic [ADDR_W-1:0] tgt_d;
    logic [8:0]        n_q;
    logic [8:0]        n_d;
    logic [8:0]        cnt_q;
    logic [8:0]        cnt_d;
    logic [31:0]       timer_q;
    logic [31:0]       timer_d;
    logic              wel_d;
    logic              epe_q;
    logic              epe_d;
    logic [3:0]        prot_d;
    sfp_arr_cmd_t      arr_q;
    sfp_arr_cmd_t      arr_d;
    sfp_esize_t        esz;

    assign esz = sfp_erase_size(op_q);

    always_comb
    begin
        st_d    = st_q;
        tgt_d   = tgt_q;
        n_d     = n_q;
        cnt_d   = cnt_q;
        timer_d = (timer_q != 32'h0) ? timer_q - 32'h1 : timer_q;
        wel_d   = wel_q;
        epe_d   = epe_q;
        prot_d  = prot_wr ? prot_wdata : prot_q;
        arr_d   = '0;
        if (wren_ok || abort)
            wel_d = wren_ok;
        unique case (st_q)
            ST_IDLE:
            begin
                if (start_prog)
                begin
                    st_d    = ST_PROG;
                    tgt_d   = addr_q;
                    n_d     = data_cnt_q;
                    cnt_d   = 9'h000;
                    timer_d = (data_cnt_q == 9'h001) ? 32'(BP_CYC) : 32'(PP_CYC);
                    wel_d   = 1'b0;
                    epe_d   = 1'b0;
                end
                else if (start_erase)
                begin
                    st_d        = ST_WAIT;
                    tgt_d       = addr_q & ~sfp_block_mask(esz);
                    timer_d     = 32'(BLK_CYC);
                    wel_d       = 1'b0;
                    epe_d       = 1'b0;
                    arr_d.erase = 1'b1;
                    arr_d.size  = esz;
                    arr_d.addr  = addr_q & ~sfp_block_mask(esz);
                    arr_d.wdata = ERASED_BYTE;
                end
            end
            ST_PROG:
            begin
                // Only the received bytes are written; the other page bytes stay erased.
                arr_d.wr    = 1'b1;
                arr_d.addr  = {tgt_q[17:8], 8'(tgt_q[7:0] + cnt_q[7:0])};
                arr_d.wdata = page_buf[8'(tgt_q[7:0] + cnt_q[7:0])];
                cnt_d       = cnt_q + 9'h001;
                if (cnt_q == n_q - 9'h001)
                    st_d = ST_WAIT;
            end
            ST_WAIT:
            begin
                if (timer_q == 32'h0)
                    st_d = ST_IDLE;
            end
            default: st_d = ST_IDLE;
        endcase
        if ((st_q != ST_IDLE) && arr_fail)
            epe_d = 1'b1;
    end

    always_ff @(posedge clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            st_q    <= ST_IDLE;
            tgt_q   <= '0;
            n_q     <= 9'h000;
            cnt_q   <= 9'h000;
            timer_q <= 32'h0;
            wel_q   <= 1'b0;
            epe_q   <= 1'b0;
            prot_q  <= PROT_RESET;
            arr_q   <= '0;
        end
        else
        begin
            st_q    <= st_d;
            tgt_q   <= tgt_d;
            n_q     <= n_d;
            cnt_q   <= cnt_d;
            timer_q <= timer_d;
            wel_q   <= wel_d;
            epe_q   <= epe_d;
            prot_q  <= prot_d;
            arr_q   <= arr_d;
        end
    end

    assign status_o.busy                     = (st_q != ST_IDLE);
    assign status_o.write_enable_latch_flag  = wel_q;
    assign status_o.program_erase_error_flag = epe_q;
    assign prot_o                            = prot_q;
    assign arr_cmd_o                         = arr_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Assertions and covers.

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_sync_n);

    a_prog_needs_wel: assert property (start_prog |-> wel_q)
        else $error("program started without write enable");
    a_erase_needs_wel: assert property (start_erase |-> wel_q)
        else $error("erase started without write enable");
    a_start_busy: assert property ((start_prog || start_erase)
        |=> status_o.busy && !status_o.write_enable_latch_flag)
        else $error("start did not show busy with flag cleared");
    a_abort_clears: assert property (abort |=> !wel_q)
        else $error("abort left write enable set");
    a_prot_refused: assert property (end_frame && prot_hit
        |-> !start_prog && !start_erase)
        else $error("protected target was started");
    a_misaligned: assert property (end_frame && !aligned
        |-> !start_prog && !start_erase)
        else $error("release off byte boundary was started");
    a_busy_holds: assert property (status_o.busy && cs_fall
        |=> !frame_ok_q)
        else $error("frame opened while busy");
    a_erase_align: assert property (arr_q.erase
        |-> (arr_q.addr & sfp_block_mask(arr_q.size)) == '0)
        else $error("erase address not block aligned");
    a_erase_once: assert property (start_erase |=> arr_q.erase ##1 !arr_q.erase)
        else $error("erase strobe not single");
    a_page_wrap: assert property (arr_q.wr |-> arr_q.addr[17:8] == tgt_q[17:8])
        else $error("program left its page");
    a_prog_len: assert property ((st_q == ST_PROG) && (cnt_q == n_q - 9'h001)
        |=> st_q == ST_WAIT)
        else $error("program byte count wrong");
    a_wren_sets: assert property (wren_ok |=> wel_q)
        else $error("write enable did not set flag");
    a_err_flag: assert property (status_o.busy && arr_fail |=> epe_q)
        else $error("failure not reported");

    c_full_page: cover property (start_prog && (data_cnt_q == PAGE_BYTES));
    c_one_byte:  cover property (start_prog && (data_cnt_q == 9'h001));
    c_erase:     cover property (start_erase);
    c_abort:     cover property (abort);

endmodule : sfp_seq

/* verilog/sfp_sync.sv */
// Two-flop synchroniser for a group of pins from outside the clock domain.
`timescale 1ns/100ps
module sfp_sync
    import sfp_pkg::*;
#(
    parameter int           W       = 1,
    parameter logic [W-1:0] RST_VAL = '0
)(
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         rst_n,
    // Pins in, synchronised copy out
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    logic [W-1:0] s1_q;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s1_q <= RST_VAL;
            q    <= RST_VAL;
        end
        else
        begin
            s1_q <= d;
            q    <= s1_q;
        end
    end

endmodule : sfp_sync
